// File: shared/sleep_ctrl_pkg.sv
package sleep_ctrl_pkg;
  // Sleep select field codes
  localparam logic [1:0] MODE_IDLE    = 2'h0;
  localparam logic [1:0] MODE_NOISE   = 2'h1;
  localparam logic [1:0] MODE_PDOWN   = 2'h2;
  localparam logic [1:0] MODE_STANDBY = 2'h3;
  // Peripheral clock stop bit positions
  localparam int PCS_CONV  = 0;
  localparam int PCS_TMR0  = 1;
  localparam int PCS_TMR1  = 2;
  localparam int PCS_TMR2  = 3;
  localparam int PCS_SPI   = 4;
  localparam int PCS_SER0  = 5;
  localparam int PCS_SER1  = 6;
  localparam int PCS_TWS   = 7;
  localparam int PCS_WIDTH = 8;
  localparam logic [7:0] PCS_RESET = 8'h00;
  // Wake timing
  localparam int HOLD_CYCLES    = 4;
  localparam int STANDBY_CYCLES = 6;
  localparam int STARTUP_DEFAULT = 16;
  localparam int CNT_W = 16;
  // Sleep state encoding
  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_SLEEP = 2'b01,
    ST_START = 2'b10,
    ST_HOLD  = 2'b11
  } sleep_state_e;
endpackage

// File: rtl/sync2.sv
module sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             reset_i,
  // Data
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // Two-stage synchroniser, first stage feeds only the second
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;
endmodule

// File: rtl/sleep_mode_clock_gating.sv
// Functional notes
// - Select field: 00 idle, 01 noise reduction, 10 power-down, 11 standby.
// - Enabled wake interrupt: start-up time, then core held four more cycles.
// - Register file and static memory keep contents across sleep.
// - Reset during sleep wakes device and restarts at the reset vector.
// - Idle stops core and nvm clocks; source, io, converter clocks run.
// - Idle wakes on any enabled interrupt, internal or external.
// - Enabled converter starts a conversion on entering idle or noise mode.
// - Noise mode stops io, core, nvm clocks; source and converter run.
// - Noise mode wake list includes converter done and nvm ready.
// - Power-down halts all clocks and stops the oscillator.
// - Power-down wakes on level irq zero, pin change, frame detect, address match.
// - Standby is power-down with oscillator running; wakes in six cycles.
// - Deep modes: serial wakes only by frame detect, two-wire by address match.
// - Outside idle, irq zero wakes only when configured as level.
// - Stopped peripheral freezes, register access blocked, resources held.
// - Clearing a stop bit resumes the peripheral in its previous state.
// - Per-peripheral stop acts in active and idle; deeper modes gate anyway.
// - Converter stays enabled in sleep; re-enable forces an extended conversion.
// - Comparator auto-off in standby and power-down; internal reference stays.
// - Reference enabled when brown-out, comparator or converter needs it.
// - Enabled watchdog and fuse-enabled brown-out stay on in every sleep mode.
module sleep_mode_clock_gating #(
  parameter int STARTUP_CYCLES = sleep_ctrl_pkg::STARTUP_DEFAULT
) (
  // Clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       reset_i,
  // Core control
  input  wire logic       sleep_arm_bit_i,
  input  wire logic [1:0] sleep_select_field_i,
  input  wire logic       sleep_instr_i,
  input  wire logic       irq_pending_i,
  // Asynchronous wake sources from pins or other domains
  input  wire logic       external_irq_zero_i,
  input  wire logic       irq_zero_level_mode_i,
  input  wire logic       pin_change_i,
  input  wire logic       watchdog_irq_i,
  input  wire logic       frame_detect_i,
  input  wire logic       twi_addr_match_i,
  // Synchronous wake sources
  input  wire logic       conv_done_i,
  input  wire logic       nvm_ready_i,
  input  wire logic       other_io_irq_i,
  // Peripheral and analog configuration
  input  wire logic [7:0] peripheral_clock_stop_reg_i,
  input  wire logic       converter_enable_i,
  input  wire logic       comparator_off_bit_i,
  input  wire logic       comparator_uses_ref_i,
  input  wire logic       watchdog_enable_i,
  input  wire logic       brownout_sleep_fuses_i,
  // Clock enables
  output logic            core_clock_en_o,
  output logic            nvm_clock_en_o,
  output logic            io_clock_en_o,
  output logic            converter_clock_en_o,
  output logic            osc_enable_o,
  output logic [7:0]      periph_clock_en_o,
  output logic [7:0]      periph_access_en_o,
  // Status and analog controls
  output logic            asleep_o,
  output logic            core_hold_o,
  output logic            vector_irq_o,
  output logic            conv_start_o,
  output logic            conv_extended_o,
  output logic            comparator_en_o,
  output logic            vref_en_o,
  output logic            watchdog_run_o,
  output logic            brownout_run_o
);
  localparam logic [1:0] MODE_IDLE    = sleep_ctrl_pkg::MODE_IDLE;
  localparam logic [1:0] MODE_NOISE   = sleep_ctrl_pkg::MODE_NOISE;
  localparam logic [1:0] MODE_PDOWN   = sleep_ctrl_pkg::MODE_PDOWN;
  localparam logic [1:0] MODE_STANDBY = sleep_ctrl_pkg::MODE_STANDBY;
  localparam int CW = sleep_ctrl_pkg::CNT_W;
  localparam logic [CW-1:0] HOLD_LAST  = CW'(sleep_ctrl_pkg::HOLD_CYCLES - 1);
  localparam logic [CW-1:0] STBY_LAST  = CW'(sleep_ctrl_pkg::STANDBY_CYCLES - 1);
  localparam logic [CW-1:0] START_LAST = CW'(STARTUP_CYCLES - 1);

  sleep_ctrl_pkg::sleep_state_e state_reg, state_next;
  logic [1:0]    mode_reg, mode_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic          conv_start_reg, conv_start_next;
  logic          conv_ext_reg, conv_ext_next;
  logic          conv_en_d_reg, conv_en_d_next;
  logic [7:0]    pcs_reg, pcs_next;
  logic [4:0]    async_sync;
  logic          irq0_s, pinc_s, wdt_s, frame_s, twi_s;
  logic          wake_any, wake_deep, wake;
  logic          deep;

  // Pin-side wake requests cross in before any logic reads them
  sync2 #(
    .WIDTH (5)
  ) u_wake_sync (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .async_i   ({external_irq_zero_i, pin_change_i, watchdog_irq_i,
                 frame_detect_i, twi_addr_match_i}),
    .sync_o    (async_sync)
  );
  assign {irq0_s, pinc_s, wdt_s, frame_s, twi_s} = async_sync;

  // Wake qualification per mode; level irq zero only outside idle
  assign wake_deep = wdt_s | (irq0_s & irq_zero_level_mode_i) | pinc_s
                   | frame_s | twi_s;
  assign wake_any  = wake_deep | irq0_s | irq_pending_i | conv_done_i
                   | nvm_ready_i | other_io_irq_i;
  always_comb begin
    unique case (mode_reg)
      MODE_IDLE:  wake = wake_any;
      MODE_NOISE: wake = wake_deep | conv_done_i | nvm_ready_i;
      default:    wake = wake_deep;
    endcase
  end

  // Sleep sequencer: run, sleep, oscillator start-up, core hold
  always_comb begin
    state_next      = state_reg;
    mode_next       = mode_reg;
    cnt_next        = cnt_reg;
    conv_start_next = 1'b0;
    unique case (state_reg)
      sleep_ctrl_pkg::ST_RUN: begin
        if (sleep_instr_i && sleep_arm_bit_i) begin
          state_next = sleep_ctrl_pkg::ST_SLEEP;
          mode_next  = sleep_select_field_i;
          conv_start_next = converter_enable_i &&
            (sleep_select_field_i == MODE_IDLE ||
             sleep_select_field_i == MODE_NOISE);
        end
      end
      sleep_ctrl_pkg::ST_SLEEP: begin
        if (wake) begin
          state_next = sleep_ctrl_pkg::ST_START;
          cnt_next   = '0;
        end
      end
      sleep_ctrl_pkg::ST_START: begin
        // Only power-down restarts the oscillator; others have it running
        if ((mode_reg == MODE_PDOWN && cnt_reg == START_LAST) ||
            (mode_reg == MODE_STANDBY && cnt_reg == STBY_LAST) ||
            (mode_reg == MODE_IDLE) || (mode_reg == MODE_NOISE)) begin
          state_next = sleep_ctrl_pkg::ST_HOLD;
          cnt_next   = '0;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      sleep_ctrl_pkg::ST_HOLD: begin
        if (cnt_reg == HOLD_LAST) begin
          state_next = sleep_ctrl_pkg::ST_RUN;
          cnt_next   = '0;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
    endcase
  end

  // Reset forces run state, so the core restarts from the vector
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg      <= sleep_ctrl_pkg::ST_RUN;
      mode_reg       <= MODE_IDLE;
      cnt_reg        <= '0;
      conv_start_reg <= 1'b0;
    end else begin
      state_reg      <= state_next;
      mode_reg       <= mode_next;
      cnt_reg        <= cnt_next;
      conv_start_reg <= conv_start_next;
    end
  end

  // Converter re-enable tracking and stop-bit register
  always_comb begin
    conv_en_d_next = converter_enable_i;
    conv_ext_next  = conv_ext_reg;
    if (converter_enable_i && !conv_en_d_reg) begin
      conv_ext_next = 1'b1;
    end else if (conv_start_reg) begin
      conv_ext_next = 1'b0;
    end
    pcs_next = peripheral_clock_stop_reg_i;
  end

  // Extended flag starts set: first conversion after reset is long too
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      conv_en_d_reg <= 1'b0;
      conv_ext_reg  <= 1'b1;
      pcs_reg       <= sleep_ctrl_pkg::PCS_RESET;
    end else begin
      conv_en_d_reg <= conv_en_d_next;
      conv_ext_reg  <= conv_ext_next;
      pcs_reg       <= pcs_next;
    end
  end

  // Clock domain gating per mode
  assign deep = (state_reg != sleep_ctrl_pkg::ST_RUN) &&
                (mode_reg == MODE_PDOWN || mode_reg == MODE_STANDBY);
  always_comb begin
    core_clock_en_o      = 1'b1;
    nvm_clock_en_o       = 1'b1;
    io_clock_en_o        = 1'b1;
    converter_clock_en_o = 1'b1;
    osc_enable_o         = 1'b1;
    if (state_reg == sleep_ctrl_pkg::ST_SLEEP) begin
      core_clock_en_o = 1'b0;
      nvm_clock_en_o  = 1'b0;
      unique case (mode_reg)
        MODE_IDLE:  io_clock_en_o = 1'b1;
        MODE_NOISE: io_clock_en_o = 1'b0;
        MODE_PDOWN: begin
          io_clock_en_o        = 1'b0;
          converter_clock_en_o = 1'b0;
          osc_enable_o         = 1'b0;
        end
        MODE_STANDBY: begin
          io_clock_en_o        = 1'b0;
          converter_clock_en_o = 1'b0;
        end
      endcase
    end else if (state_reg != sleep_ctrl_pkg::ST_RUN) begin
      // Core stays stopped through start-up and the hold cycles
      core_clock_en_o = 1'b0;
      nvm_clock_en_o  = 1'b0;
      io_clock_en_o   = !deep || (state_reg == sleep_ctrl_pkg::ST_HOLD);
      converter_clock_en_o = io_clock_en_o || (mode_reg == MODE_NOISE);
      osc_enable_o    = !(mode_reg == MODE_PDOWN && state_reg == sleep_ctrl_pkg::ST_SLEEP);
    end
  end

  // Per-peripheral clock and register access; frozen, not reset
  genvar gi;
  generate
    for (gi = 0; gi < sleep_ctrl_pkg::PCS_WIDTH; gi++) begin : g_pcs
      assign periph_clock_en_o[gi]  = !pcs_reg[gi] && io_clock_en_o;
      assign periph_access_en_o[gi] = !pcs_reg[gi];
    end
  endgenerate

  // Status and analog enables
  assign asleep_o        = (state_reg == sleep_ctrl_pkg::ST_SLEEP);
  assign core_hold_o     = (state_reg != sleep_ctrl_pkg::ST_RUN);
  assign vector_irq_o    = (state_reg == sleep_ctrl_pkg::ST_HOLD) && (cnt_reg == HOLD_LAST);
  assign conv_start_o    = conv_start_reg;
  assign conv_extended_o = conv_ext_reg;
  // Comparator forced off in deep modes only
  assign comparator_en_o = !comparator_off_bit_i && !deep;
  assign vref_en_o       = brownout_sleep_fuses_i || converter_enable_i ||
                           (!comparator_off_bit_i && comparator_uses_ref_i);
  assign watchdog_run_o  = watchdog_enable_i;
  assign brownout_run_o  = brownout_sleep_fuses_i;
endmodule

// File: sim/sleep_mode_clock_gating_assertions.sv
module sleep_mode_clock_gating_assertions (
  // Watched ports, grouped by type to keep the checker short
  input wire logic       ref_clk_i, reset_i, sleep_arm_bit_i, sleep_instr_i, asleep_o,
  input wire logic [1:0] sleep_select_field_i,
  input wire logic [7:0] peripheral_clock_stop_reg_i, periph_clock_en_o, periph_access_en_o,
  input wire logic       converter_enable_i, comparator_off_bit_i, comparator_uses_ref_i,
  input wire logic       watchdog_enable_i, brownout_sleep_fuses_i, core_clock_en_o,
  input wire logic       nvm_clock_en_o, io_clock_en_o, converter_clock_en_o, osc_enable_o,
  input wire logic       core_hold_o, vector_irq_o, conv_start_o, comparator_en_o,
  input wire logic       vref_en_o, watchdog_run_o, brownout_run_o, conv_extended_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] mode_reg;
  logic [1:0] mode_next;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  // Own copy of the mode, taken where a request is accepted in run state
  always_comb begin
    mode_next = mode_reg;
    if (sleep_instr_i && sleep_arm_bit_i && !core_hold_o) mode_next = sleep_select_field_i;
  end
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) mode_reg <= sleep_ctrl_pkg::MODE_IDLE;
    else mode_reg <= mode_next;
  end
  AST_ENTER: assert property (sleep_instr_i && sleep_arm_bit_i && !core_hold_o |=>
    asleep_o && !core_clock_en_o) else $error("armed sleep not entered");
  AST_NOARM: assert property (sleep_instr_i && !sleep_arm_bit_i && !core_hold_o |=>
    !asleep_o) else $error("sleep entered without arm bit");
  AST_IDLE: assert property (asleep_o && mode_reg == sleep_ctrl_pkg::MODE_IDLE |->
    !core_clock_en_o && !nvm_clock_en_o && io_clock_en_o && converter_clock_en_o
    && osc_enable_o) else $error("idle clock set wrong");
  AST_NOISE: assert property (asleep_o && mode_reg == sleep_ctrl_pkg::MODE_NOISE |->
    !core_clock_en_o && !nvm_clock_en_o && !io_clock_en_o && converter_clock_en_o
    && osc_enable_o) else $error("noise clock set wrong");
  AST_PDOWN: assert property (asleep_o && mode_reg == sleep_ctrl_pkg::MODE_PDOWN |->
    !core_clock_en_o && !io_clock_en_o && !converter_clock_en_o && !osc_enable_o)
    else $error("power-down clock set wrong");
  AST_STBY: assert property (asleep_o && mode_reg == sleep_ctrl_pkg::MODE_STANDBY |->
    !core_clock_en_o && !io_clock_en_o && !converter_clock_en_o && osc_enable_o)
    else $error("standby clock set wrong");
  AST_HOLD: assert property ($fell(asleep_o) && !mode_reg[1] |-> core_hold_o ##4
    vector_irq_o ##1 !core_hold_o && core_clock_en_o) else $error("wake hold not four");
  AST_SIX: assert property ($fell(asleep_o) && mode_reg == sleep_ctrl_pkg::MODE_STANDBY
    |-> ##9 vector_irq_o) else $error("standby wake length wrong");
  AST_CONV: assert property ($rose(asleep_o) && !mode_reg[1] && converter_enable_i
    |-> ##[0:1] conv_start_o) else $error("no conversion on sleep entry");
  AST_EXT: assert property ($rose(converter_enable_i) |=> conv_extended_o)
    else $error("no extended conversion after re-enable");
  AST_CMP: assert property (asleep_o && mode_reg[1] |-> !comparator_en_o)
    else $error("comparator on in deep sleep");
  AST_VREF: assert property (vref_en_o == (brownout_sleep_fuses_i || converter_enable_i
    || (!comparator_off_bit_i && comparator_uses_ref_i))) else $error("reference wrong");
  AST_KEEP: assert property (watchdog_run_o == watchdog_enable_i
    && brownout_run_o == brownout_sleep_fuses_i) else $error("watchdog or brown-out gated");
  AST_PACC: assert property (periph_access_en_o == ~$past(peripheral_clock_stop_reg_i))
    else $error("peripheral access wrong");
  AST_PCLK: assert property (periph_clock_en_o == (periph_access_en_o
    & {8{io_clock_en_o}})) else $error("peripheral clock wrong");
  // Main scenarios reached
  cover property ($fell(asleep_o) && mode_reg == sleep_ctrl_pkg::MODE_PDOWN);
  cover property (conv_start_o);
  cover property (vector_irq_o && mode_reg == sleep_ctrl_pkg::MODE_STANDBY);
endmodule

// File: sim/core_model.sv
module core_model (
  // Clock and device status
  input  wire logic       ref_clk_i,
  input  wire logic       asleep_i,
  // Sleep request and level wake
  output logic            arm_o,
  output logic [1:0]      mode_o,
  output logic            instr_o,
  output logic            irq_zero_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {arm_o, mode_o, instr_o, irq_zero_o} = '0;
  end
  // Arm, select and execute in one cycle; arm dropped at once so no stray sleep
  task automatic go_sleep(input logic [1:0] mode, input logic arm);
    @(posedge ref_clk_i) #1;
    arm_o = arm;
    mode_o = mode;
    instr_o = 1'b1;
    @(posedge ref_clk_i) #1;
    instr_o = 1'b0;
    arm_o = 1'b0;
  endtask
  // Level wake held until the device is awake, bounded
  task automatic level_wake();
    int n;
    n = 0;
    irq_zero_o = 1'b1;
    // Status read off the edge, once it has settled
    while (asleep_i && n < 300) begin
      @(posedge ref_clk_i) #1;
      n++;
    end
    irq_zero_o = 1'b0;
  endtask
endmodule

// File: sim/sleep_mode_clock_gating_test.sv
module sleep_mode_clock_gating_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STARTUP = 2; // Short oscillator start keeps the run brief
  logic ref_clk_i = 0, reset_i = 1, irq_pending_i = 0, level_mode = 0, edge_irq = 0;
  logic conv_done = 0, nvm_ready = 0, conv_en = 0, wdt_en = 1, bod_fuses = 1;
  logic [3:0] src = 0;
  logic [7:0] stop = 0;
  logic arm, instr, irq0, asleep, hold, vec, core_en, io_en, cv_en, osc, cmp;
  logic ext, vref, wdt_run, bod_run;
  logic other_irq = 0, cmp_off = 0, cmp_ref = 1;
  logic [1:0] mode;
  logic [7:0] pclk, pacc;
  int fails = 0, n_tests = 0, cyc = 0;
  core_model core (.ref_clk_i(ref_clk_i), .asleep_i(asleep), .arm_o(arm), .mode_o(mode),
    .instr_o(instr), .irq_zero_o(irq0));
  sleep_mode_clock_gating #(.STARTUP_CYCLES(STARTUP)) DUT (.ref_clk_i(ref_clk_i),
    .reset_i(reset_i), .sleep_arm_bit_i(arm), .sleep_select_field_i(mode),
    .sleep_instr_i(instr), .irq_pending_i(irq_pending_i), .external_irq_zero_i(irq0 | edge_irq),
    .irq_zero_level_mode_i(level_mode), .pin_change_i(src[0]), .watchdog_irq_i(src[1]),
    .frame_detect_i(src[2]), .twi_addr_match_i(src[3]), .conv_done_i(conv_done),
    .nvm_ready_i(nvm_ready), .other_io_irq_i(other_irq), .peripheral_clock_stop_reg_i(stop),
    .converter_enable_i(conv_en), .comparator_off_bit_i(cmp_off),
    .comparator_uses_ref_i(cmp_ref),
    .watchdog_enable_i(wdt_en), .brownout_sleep_fuses_i(bod_fuses),
    .core_clock_en_o(core_en), .nvm_clock_en_o(), .io_clock_en_o(io_en),
    .converter_clock_en_o(cv_en), .osc_enable_o(osc), .periph_clock_en_o(pclk),
    .periph_access_en_o(pacc), .asleep_o(asleep), .core_hold_o(hold), .vector_irq_o(vec),
    .conv_start_o(), .conv_extended_o(ext), .comparator_en_o(cmp), .vref_en_o(vref),
    .watchdog_run_o(wdt_run), .brownout_run_o(bod_run));
  always #20 ref_clk_i = ~ref_clk_i;
  // Hang guard, far above the expected run length
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      wrap_up();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Cycles from the fall of asleep to the vector pulse, then back in run
  task automatic wake_len(input int exp);
    int n, m;
    n = 0;
    m = 0;
    while (asleep === 1'b1 && n < 300) begin
      tick(1);
      n++;
    end
    while (vec !== 1'b1 && m < 300) begin
      tick(1);
      m++;
    end
    chk("wake cycles", exp[7:0], m[7:0]);
    tick(1);
    chk("back in run", 8'h01, {hold, core_en});
  endtask
  task automatic sleep_as(input logic [1:0] md, input logic [7:0] clks);
    core.go_sleep(md, 1'b1);
    chk("asleep", 8'h01, asleep);
    chk("clock set", clks, {core_en, io_en, cv_en, osc});
  endtask
  task automatic t_idle();
    conv_en = 1;
    sleep_as(sleep_ctrl_pkg::MODE_IDLE, 8'h07);
    irq_pending_i = 1;
    wake_len(4);
    chk("extended cleared", 8'h00, ext);
    {irq_pending_i, conv_en} = 2'b00;
    core.go_sleep(sleep_ctrl_pkg::MODE_PDOWN, 1'b0);
    tick(2);
    chk("unarmed", 8'h00, asleep);
    // Converter back on: next conversion must be the long one
    conv_en = 1;
    tick(2);
    chk("extended set", 8'h01, ext);
    conv_en = 0;
    $display("idle and arm test done");
  endtask
  task automatic t_noise();
    sleep_as(sleep_ctrl_pkg::MODE_NOISE, 8'h03);
    chk("noise periph clocks", 8'h00, pclk);
    {irq_pending_i, other_irq} = 2'b11;
    tick(5);
    chk("pending ignored", 8'h01, asleep);
    {irq_pending_i, other_irq} = 2'b00;
    nvm_ready = 1;
    wake_len(4);
    nvm_ready = 0;
    $display("noise test done");
  endtask
  // Every deep wake source; converter done and edge irq zero refused
  task automatic t_deep();
    for (int i = 0; i < 4; i++) begin
      sleep_as(sleep_ctrl_pkg::MODE_PDOWN, 8'h00);
      chk("comparator", 8'h00, cmp);
      {conv_done, edge_irq} = 2'b11;
      tick(6);
      chk("refused wake", 8'h01, asleep);
      {conv_done, edge_irq} = 2'b00;
      src[i] = 1'b1;
      wake_len(STARTUP + 3);
      src = 0;
    end
    level_mode = 1;
    sleep_as(sleep_ctrl_pkg::MODE_STANDBY, 8'h01);
    fork
      core.level_wake();
      wake_len(9);
    join
    level_mode = 0;
    $display("deep sleep test done");
  endtask
  task automatic t_reset_pcs();
    sleep_as(sleep_ctrl_pkg::MODE_PDOWN, 8'h00);
    tick(3);
    reset_i = 1;
    tick(1);
    reset_i = 0;
    tick(1);
    chk("reset wake", 8'h01, {asleep, hold, core_en});
    stop = 8'hA5; // Converter already off before its stop bit
    tick(2);
    chk("access", 8'h5A, pacc);
    sleep_as(sleep_ctrl_pkg::MODE_IDLE, 8'h07);
    chk("idle periph clocks", 8'h5A, pclk);
    // Edge-mode irq zero is a valid wake source in idle only
    edge_irq = 1;
    wake_len(4);
    edge_irq = 0;
    stop = 8'h00;
    tick(2);
    chk("restart", 8'hFF, pclk);
    // Analog enables: every requester off, comparator without reference, all on
    {cmp_off, bod_fuses, wdt_en} = 3'b100;
    tick(1);
    chk("analog off", 8'h00, {vref, cmp, wdt_run, bod_run});
    {cmp_off, cmp_ref, wdt_en} = 3'b001;
    tick(1);
    chk("comparator no ref", 8'h06, {vref, cmp, wdt_run, bod_run});
    {cmp_ref, bod_fuses} = 2'b11;
    tick(1);
    chk("analog on", 8'h0F, {vref, cmp, wdt_run, bod_run});
    $display("reset and peripheral test done");
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    tick(12);
    reset_i = 0;
    tick(1);
    t_idle();
    t_noise();
    t_deep();
    t_reset_pcs();
    wrap_up();
  end
endmodule
bind sleep_mode_clock_gating sleep_mode_clock_gating_assertions u_chk (.*);
